/* design/sapc_regs.svh */
// constants for the sampling converter control logic
// assumes a 50 MHz system clock
`ifndef SAPC_REGS_SVH
`define SAPC_REGS_SVH
`define SAPC_CLK_NS       20
`define SAPC_CONV_MAX_NS  2700
`define SAPC_CONV_CYC     ((`SAPC_CONV_MAX_NS) / (`SAPC_CLK_NS))
`define SAPC_CNT_W        7
`define SAPC_RES_W        12
`define SAPC_MSB          11
`define SAPC_HI_LO        8
`define SAPC_STEP_CYC     8
`endif

/* design/sapc_pkg.sv */
// types for the sampling converter control logic
// assumes sapc_regs.svh constants
`include "sapc_regs.svh"
package sapc_pkg;
  typedef logic [`SAPC_RES_W-1:0] sapc_word_type;
  typedef enum logic [1:0] {
    SAPC_IDLE = 2'b00,
    SAPC_CONV = 2'b01,
    SAPC_LOAD = 2'b10
  } sapc_state_type;
endpackage

/* design/sapc_sar_if.sv */
// carrier between control and approximation register
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
interface sapc_sar_if;
  import sapc_pkg::*;
  logic          clear;
  logic          step;
  logic          cmp_hi;
  sapc_word_type word;
  logic          done;
  modport ctl (output clear, output step, output cmp_hi,
               input word, input done);
  modport sar (input clear, input step, input cmp_hi,
               output word, output done);
endinterface
`default_nettype wire

/* design/sapc_sar.sv */
// successive approximation register, one bit per step
// assumes clear before the first step of a conversion
`timescale 1ns/1ps
`default_nettype none
`include "sapc_regs.svh"
module sapc_sar (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control side
  sapc_sar_if.sar  sif
);
  import sapc_pkg::*;
  sapc_word_type    word_q;
  logic [3:0]       bit_q;
  logic             done_q;

  // msb first trial and decision
  always_ff @(posedge clk) begin
    if (srst || sif.clear) begin
      word_q <= {1'b1, {(`SAPC_RES_W-1){1'b0}}};
      bit_q  <= 4'(`SAPC_MSB);
      done_q <= 1'b0;
    end else if (sif.step && !done_q) begin
      word_q[bit_q] <= sif.cmp_hi;
      if (bit_q != 4'h0) begin
        word_q[bit_q - 4'h1] <= 1'b1;
        bit_q <= bit_q - 4'h1;
      end else begin
        done_q <= 1'b1;
      end
    end
  end
  assign sif.word = word_q;
  assign sif.done = done_q;

  chk_sar_msb_first: assert property (@(posedge clk) disable iff (srst)
    sif.clear |=> word_q == 12'h800)
    else $error("trial word not msb after clear");
endmodule
`default_nettype wire

/* design/sapc_ctl.sv */
// control and output logic of a 12-bit sampling converter
// assumes host strobes synchronous to clk; comparator decision on cmp_hi
`timescale 1ns/1ps
`default_nettype none
`include "sapc_regs.svh"
module sapc_ctl (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // host strobes
  input  wire logic             chip_sel_n,
  input  wire logic             read_n,
  input  wire logic             high_byte_select,
  // comparator decision from analog front end
  input  wire logic             cmp_hi,
  // converter status
  output logic                  busy_n,
  output logic                  acquire,
  // three-state data pins, enable low while driving
  output logic [7:0]            upper_data_pins_o,
  output logic [7:0]            upper_data_pins_oe_n,
  output logic [3:0]            shared_low_data_pins_o,
  output logic [3:0]            shared_low_data_pins_oe_n,
  // latched result for reference
  output sapc_pkg::sapc_word_type result_bits
);
  import sapc_pkg::*;

  sapc_sar_if sif ();
  sapc_sar u_sar (
    .clk  (clk),
    .srst (srst),
    .sif  (sif)
  );

  sapc_state_type      state_q;
  logic [2:0]          div_q;
  logic [`SAPC_CNT_W-1:0] conv_cnt_q;
  sapc_word_type       latch_q;
  logic                read_q;
  logic                start;
  logic                rd_en;
  logic                step_en;
  logic [`SAPC_RES_W-1:0] pins;

  // host gating
  assign rd_en = !chip_sel_n && !read_n;
  assign start = rd_en && !high_byte_select
                 && !read_q && state_q == SAPC_IDLE;

  always_ff @(posedge clk) begin
    if (srst) begin
      read_q <= 1'b0;
    end else begin
      read_q <= rd_en;
    end
  end

  // sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= SAPC_IDLE;
    end else begin
      case (state_q)
        SAPC_IDLE: begin
          if (start) begin
            state_q <= SAPC_CONV;
          end
        end
        SAPC_CONV: begin
          if (sif.done) begin
            state_q <= SAPC_LOAD;
          end
        end
        SAPC_LOAD: begin
          state_q <= SAPC_IDLE;
        end
        default: begin
          state_q <= SAPC_IDLE;
        end
      endcase
    end
  end

  // internal bit clock divider, synchronised to each start
  always_ff @(posedge clk) begin
    if (srst || start) begin
      div_q <= 3'h0;
    end else if (state_q == SAPC_CONV) begin
      div_q <= div_q + 3'h1;
    end
  end
  assign step_en = (state_q == SAPC_CONV)
                   && div_q == 3'(`SAPC_STEP_CYC - 1);

  assign sif.clear  = start;
  assign sif.step   = step_en;
  assign sif.cmp_hi = cmp_hi;

  // output latches
  always_ff @(posedge clk) begin
    if (srst) begin
      latch_q <= 12'h000;
    end else if (state_q == SAPC_LOAD) begin
      latch_q <= sif.word;
    end
  end

  // conversion length monitor
  always_ff @(posedge clk) begin
    if (srst || state_q == SAPC_IDLE) begin
      conv_cnt_q <= '0;
    end else begin
      conv_cnt_q <= conv_cnt_q + 7'h01;
    end
  end

  // busy low from start through latch load
  assign busy_n  = state_q == SAPC_IDLE;
  assign acquire = busy_n;

  // byte steering
  assign pins = high_byte_select ?
    {latch_q[11:8], 4'h0, latch_q[11:8]} :
    latch_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      upper_data_pins_o      <= 8'h00;
      shared_low_data_pins_o <= 4'h0;
    end else begin
      upper_data_pins_o      <= pins[11:4];
      shared_low_data_pins_o <= pins[3:0];
    end
  end

  // output enables, low while driving
  assign upper_data_pins_oe_n      = {8{!rd_en}};
  assign shared_low_data_pins_oe_n = {4{!rd_en}};
  assign result_bits = latch_q;

  // checks
  chk_start_gate: assert property (@(posedge clk) disable iff (srst)
    (state_q == SAPC_IDLE && high_byte_select) |=> state_q != SAPC_CONV)
    else $error("conversion started with byte select high");
  chk_desel_ign: assert property (@(posedge clk) disable iff (srst)
    chip_sel_n |-> (upper_data_pins_oe_n == 8'hFF && !start))
    else $error("strobes seen while deselected");
  chk_start_run: assert property (@(posedge clk) disable iff (srst)
    start |=> state_q == SAPC_CONV && !busy_n)
    else $error("start did not begin conversion");
  chk_drive_en: assert property (@(posedge clk) disable iff (srst)
    (!chip_sel_n && !read_n) |-> shared_low_data_pins_oe_n == 4'h0)
    else $error("data not driven during read");
  chk_busy_hold: assert property (@(posedge clk) disable iff (srst)
    $fell(busy_n) |-> !busy_n[*8])
    else $error("busy released early");
  chk_no_restart: assert property (@(posedge clk) disable iff (srst)
    state_q == SAPC_CONV |-> !sif.clear)
    else $error("running conversion restarted");
  chk_conv_bound: assert property (@(posedge clk) disable iff (srst)
    {1'b0, conv_cnt_q} <= 8'(`SAPC_CONV_CYC))
    else $error("conversion too long");
  chk_acq_busy: assert property (@(posedge clk) disable iff (srst)
    acquire == busy_n)
    else $error("acquire differs from busy");
  chk_oe_both: assert property (@(posedge clk) disable iff (srst)
    upper_data_pins_oe_n == {8{shared_low_data_pins_oe_n[0]}})
    else $error("data pin enables disagree");
  chk_latch_busy: assert property (@(posedge clk) disable iff (srst)
    $rose(busy_n) |-> latch_q == $past(sif.word))
    else $error("busy rose before latch held result");
  chk_byte_high: assert property (@(posedge clk) disable iff (srst)
    high_byte_select |=> upper_data_pins_o[3:0] == 4'h0
      || $changed(latch_q))
    else $error("middle nibble not low in high byte");
  chk_full_word: assert property (@(posedge clk) disable iff (srst)
    (!high_byte_select && $stable(latch_q)) |=>
      {upper_data_pins_o, shared_low_data_pins_o} == $past(latch_q))
    else $error("full word misplaced");

  cov_conv: cover property (@(posedge clk) disable iff (srst)
    $rose(busy_n));
  cov_hbyte: cover property (@(posedge clk) disable iff (srst)
    rd_en && high_byte_select);
  cov_blocked: cover property (@(posedge clk) disable iff (srst)
    rd_en && state_q == SAPC_CONV);
  cov_full_read: cover property (@(posedge clk) disable iff (srst)
    rd_en && !high_byte_select && state_q == SAPC_IDLE);
endmodule
`default_nettype wire

/* test/sapc_cmp_model.sv */
// comparator stand-in that answers each trial bit from a target code
// assumes one bit decision per eight clocks after busy_n falls
`timescale 1ns/1ps
`default_nettype none
module sapc_cmp_model (
  // clock and status
  input  wire logic        clk,
  input  wire logic        busy_n,
  // target code and decision
  input  wire logic [11:0] target,
  output logic             cmp_hi
);
  logic [6:0] n_q;
  logic       tog_q;
  always_ff @(posedge clk) begin
    tog_q <= ~tog_q;
    n_q <= busy_n ? 7'h00 : n_q + 7'h01;
  end
  // outside a conversion the decision wanders, so nothing leans on it
  always_comb begin
    if (busy_n || n_q[6:3] > 4'hB) begin
      cmp_hi = tog_q;
    end else begin
      cmp_hi = target[4'hB - n_q[6:3]];
    end
  end
  initial tog_q = 1'b0;
endmodule
`default_nettype wire

/* test/sapc_ctl_bench.sv */
// self-checking bench for the converter control logic
// assumes sapc_ctl and the comparator stand-in, clock 50 MHz
`timescale 1ns/1ps
`default_nettype none
module sapc_ctl_bench;
  import sapc_pkg::*;
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  logic          cs_n = 1'b1;
  logic          rd_n = 1'b1;
  logic          hbs = 1'b0;
  logic          cmp_hi;
  logic          busy_n;
  logic          acq;
  logic [7:0]    up_o;
  logic [7:0]    up_oe_n;
  logic [3:0]    lo_o;
  logic [3:0]    lo_oe_n;
  sapc_word_type res;
  logic [11:0]   tgt = 12'h000;
  logic [11:0]   prev = 12'h000;
  int            err_total = 0;
  int            tests_run = 0;
  int            cyc = 0;
  int            n;
  always #10 clk = ~clk;
  sapc_ctl sapc_ctl_inst (
    .clk(clk), .srst(srst), .chip_sel_n(cs_n), .read_n(rd_n),
    .high_byte_select(hbs), .cmp_hi(cmp_hi), .busy_n(busy_n),
    .acquire(acq), .upper_data_pins_o(up_o), .upper_data_pins_oe_n(up_oe_n),
    .shared_low_data_pins_o(lo_o), .shared_low_data_pins_oe_n(lo_oe_n),
    .result_bits(res));
  sapc_cmp_model sapc_cmp_model_inst (
    .clk(clk), .busy_n(busy_n), .target(tgt), .cmp_hi(cmp_hi));
  function automatic logic [11:0] pins(input logic [11:0] w, input logic h);
    pins = h ? {w[11:8], 4'h0, w[11:8]} : w;
  endfunction
  task automatic chk_w(input string nm, input logic [11:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, g);
    chk_w(nm, {11'h000, e}, {11'h000, g});
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic drive(input logic c, r, h);
    @(negedge clk);
    cs_n = c;
    rd_n = r;
    hbs = h;
    #1;
  endtask
  task automatic convert(input logic [11:0] t, input bit again);
    repeat (30) @(negedge clk);
    drive(1'b0, 1'b0, 1'b1);
    chk_w("oe read", 12'h000, {up_oe_n, lo_oe_n});
    repeat (2) @(negedge clk);
    chk_w("high byte", pins(prev, 1'b1), {up_o, lo_o});
    chk_b("no start", 1'b1, busy_n);
    drive(1'b1, 1'b1, 1'b0);
    chk_w("oe idle", 12'hFFF, {up_oe_n, lo_oe_n});
    tgt = t;
    drive(1'b0, 1'b0, 1'b0);
    @(negedge clk);
    chk_b("busy start", 1'b0, busy_n);
    chk_b("acquire run", 1'b0, acq);
    @(negedge clk);
    chk_w("full word", pins(prev, 1'b0), {up_o, lo_o});
    drive(1'b1, 1'b1, 1'b0);
    if (again) begin
      drive(1'b0, 1'b0, 1'b0);
      drive(1'b1, 1'b1, 1'b0);
    end
    n = 0;
    while (busy_n === 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk_b("in time", 1'b1, n < 133);
    chk_w("result", t, res);
    prev = t;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    logic [11:0] corner [4] = '{12'h000, 12'hFFF, 12'hA5A, 12'h5A5};
    void'($urandom(58));
    repeat (10) @(negedge clk);
    srst = 1'b0;
    chk_b("reset busy", 1'b1, busy_n);
    chk_b("reset acquire", 1'b1, acq);
    chk_w("reset latch", 12'h000, res);
    for (int i = 0; i < 8; i++) begin
      convert(i < 4 ? corner[i] : 12'($urandom), i[0]);
    end
    drive(1'b1, 1'b0, 1'b0);
    repeat (3) @(negedge clk);
    chk_b("deselected", 1'b1, busy_n);
    chk_w("oe deselected", 12'hFFF, {up_oe_n, lo_oe_n});
    stop_test();
  end
endmodule
`default_nettype wire
